// *** rtl/scc_regs.svh ***
// Constants for the stepper chop and current select block.
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SCC_CLK_PERIOD_PS 10000
`define SCC_CLK_HZ 100000000
`define SCC_PROG_LOW_PS 200000
`define SCC_PROG_LOW_CYC ((`SCC_PROG_LOW_PS + `SCC_CLK_PERIOD_PS - 1) / `SCC_CLK_PERIOD_PS)
`define SCC_OSC_HZ 20000
`define SCC_OSC_CYC (`SCC_CLK_HZ / `SCC_OSC_HZ)
`define SCC_OSC_W 16
`define SCC_CNT_W 8

// ----------------------------------------
// Configuration word layout and reset
// ----------------------------------------
`define SCC_CFG_RESET 6'h00
`define SCC_BIT_LEVEL0 0
`define SCC_BIT_LEVEL1 1
`define SCC_BIT_TON_LOW 2
`define SCC_BIT_TON_HIGH 3
`define SCC_BIT_DIVIDE 4
`define SCC_BIT_STYLE 5

// ----------------------------------------
// Current levels
// ----------------------------------------
`define SCC_NOM_REF_MV 500
`define SCC_PCT_NOM 7'h64
`define SCC_PCT_L00 7'h28
`define SCC_PCT_L01 7'h32
`define SCC_PCT_L10 7'h46
`define SCC_PCT_L11 7'h55

`endif

// *** rtl/scc_pkg.sv ***
// Types for the stepper chop and current select block.
`include "scc_regs.svh"

package scc_pkg;

  typedef enum logic [1:0] {
    SCC_ARMED = 2'b00,
    SCC_LOW_WAIT = 2'b01,
    SCC_SHIFTED = 2'b11
  } scc_prog_t;

  typedef struct packed {
    logic [`SCC_OSC_W-1:0] cnt;
    logic pulse;
  } scc_osc_state_t;

  typedef struct packed {
    logic [5:0] cfg;
    scc_prog_t prog;
    logic [`SCC_CNT_W-1:0] low_cnt;
    logic div_tog;
    logic chop_on;
    logic out_en;
    logic [3:0] drive;
    logic reduced;
    logic [9:0] ref_mv;
    logic open_loop;
  } scc_top_state_t;

endpackage

// *** rtl/scc_osc.sv ***
// Oscillator period counter standing for the RC network.
`timescale 1ns/1ps
`include "scc_regs.svh"

module scc_osc #(
  parameter int OSC_PERIOD = `SCC_OSC_CYC
) (
  input logic clk,
  input logic rstn,
  input logic restart,
  output logic [`SCC_OSC_W-1:0] cnt,
  output logic pulse
);

  localparam logic [`SCC_OSC_W-1:0] LAST = `SCC_OSC_W'(OSC_PERIOD - 1);

  scc_pkg::scc_osc_state_t s;
  scc_pkg::scc_osc_state_t next_s;

  // ----------------------------------------
  // Period count
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    if (restart || s.cnt == LAST)
    begin
      next_s.cnt = '0;
    end
    else
    begin
      next_s.cnt = s.cnt + `SCC_OSC_W'(1);
    end
    next_s.pulse = (next_s.cnt == '0);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign cnt = s.cnt;
  assign pulse = s.pulse;

  chk_osc_wrap: assert property (@(posedge clk) disable iff (!rstn)
    (s.cnt == LAST && !restart) |=> (s.cnt == '0 && s.pulse))
    else $error("Oscillator did not wrap at end of period.");

endmodule

// *** rtl/scc_top.sv ***
// Mode decode, configuration word and chopping control of the stepper driver.
// Function
// - In open loop the chop rate is the full oscillator rate whatever the divide bit holds.
// - In open loop on-time codes 00, 01 and 10 give 75, 50 and 100 percent of the period; 11 disables the output.
// - In closed loop the chop rate is the oscillator rate with the divide bit low and half of it with the bit high.
// - In closed loop there is a nominal level at a 0.5 V reference and four reduced levels scaling it.
// - Level codes 00, 01, 10 and 11 give 40 percent, a parameter, 70 and 85 percent of nominal.
// - In full style reduction is asserted by both A inputs high, both B inputs high, exactly one phase input high, or the request input.
// - In simplified style reduction is asserted by the alternate input low or the request input high.
// - In full style the output stage is disabled whenever both A inputs or both B inputs are low.
// - A six-bit word holds the configuration and its top bit selects full style when set.
// - In full style half-step drive one active phase gives the reduced level and two active phases nominal.
// - Loop select high chooses open loop and low chooses closed loop in both styles.
// - With all four phase inputs low one bit, the XOR of the two auxiliary inputs, shifts in at bit zero.
// - An all-low interval under 0.2 us shifts nothing and each further shift needs an input to rise first.
// - In simplified style the third input is an active-high enable and the first two set phase A and B.
`timescale 1ns/1ps
`include "scc_regs.svh"

module scc_top #(
  parameter int OSC_PERIOD = `SCC_OSC_CYC,
  parameter int PROG_LOW_CYC = `SCC_PROG_LOW_CYC,
  parameter logic [6:0] LEVEL01_PCT = `SCC_PCT_L01
) (
  input logic clk,
  input logic rstn,
  input logic phase_a_input,
  input logic phase_a_bar_input,
  input logic phase_b_input,
  input logic phase_b_bar_input,
  input logic reduction_request_input,
  input logic loop_select_input,
  input logic over_threshold,
  input logic ext_reset_request,
  output logic [3:0] drive_out,
  output logic chop_on,
  output logic output_enable,
  output logic reduced_current,
  output logic [9:0] ref_level_mv,
  output logic open_loop,
  output logic full_input_style,
  output logic [5:0] config_word
);

  localparam logic [`SCC_OSC_W-1:0] THR_100 = `SCC_OSC_W'(OSC_PERIOD);
  localparam logic [`SCC_OSC_W-1:0] THR_75 = `SCC_OSC_W'(OSC_PERIOD - OSC_PERIOD / 4);
  localparam logic [`SCC_OSC_W-1:0] THR_50 = `SCC_OSC_W'(OSC_PERIOD / 2);
  localparam logic [`SCC_CNT_W-1:0] LOW_LAST = `SCC_CNT_W'(PROG_LOW_CYC - 1);

  scc_pkg::scc_top_state_t s;
  scc_pkg::scc_top_state_t next_s;
  logic [`SCC_OSC_W-1:0] osc_cnt;
  logic osc_pulse;

  function automatic logic [6:0] level_pct(input logic [5:0] cfg);
    unique case ({cfg[`SCC_BIT_LEVEL0], cfg[`SCC_BIT_LEVEL1]})
      2'b00: level_pct = `SCC_PCT_L00;
      2'b01: level_pct = LEVEL01_PCT;
      2'b10: level_pct = `SCC_PCT_L10;
      2'b11: level_pct = `SCC_PCT_L11;
    endcase
  endfunction

  function automatic logic [`SCC_OSC_W-1:0] on_limit(input logic [5:0] cfg);
    unique case ({cfg[`SCC_BIT_TON_LOW], cfg[`SCC_BIT_TON_HIGH]})
      2'b00: on_limit = THR_75;
      2'b01: on_limit = THR_50;
      2'b10: on_limit = THR_100;
      2'b11: on_limit = '0;
    endcase
  endfunction

  scc_osc #(
    .OSC_PERIOD(OSC_PERIOD)
  ) scc_osc_inst (
    .clk(clk),
    .rstn(rstn),
    .restart(ext_reset_request),
    .cnt(osc_cnt),
    .pulse(osc_pulse)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic all_low;
  logic ser_bit;
  logic ton_off;
  logic chop_pulse;
  logic style_en;
  logic [6:0] pct;
  logic [2:0] active;

  always_comb
  begin
    next_s = s;
    all_low = !(phase_a_input | phase_a_bar_input | phase_b_input | phase_b_bar_input);
    ser_bit = reduction_request_input ^ loop_select_input;
    ton_off = (s.cfg[`SCC_BIT_TON_HIGH:`SCC_BIT_TON_LOW] == 2'b11);
    active = 3'(phase_a_input) + 3'(phase_a_bar_input) + 3'(phase_b_input)
           + 3'(phase_b_bar_input);
    chop_pulse = osc_pulse && (!s.cfg[`SCC_BIT_DIVIDE] || s.div_tog);
    pct = `SCC_PCT_NOM;
    style_en = 1'b0;
    // Programming: qualify the all-low interval, then shift once.
    unique case (s.prog)
      scc_pkg::SCC_ARMED:
      begin
        if (all_low)
        begin
          next_s.prog = scc_pkg::SCC_LOW_WAIT;
          next_s.low_cnt = `SCC_CNT_W'(1);
        end
      end
      scc_pkg::SCC_LOW_WAIT:
      begin
        if (!all_low)
        begin
          next_s.prog = scc_pkg::SCC_ARMED;
        end
        else if (s.low_cnt >= LOW_LAST)
        begin
          next_s.cfg = {s.cfg[4:0], ser_bit};
          next_s.prog = scc_pkg::SCC_SHIFTED;
        end
        else
        begin
          next_s.low_cnt = s.low_cnt + `SCC_CNT_W'(1);
        end
      end
      scc_pkg::SCC_SHIFTED:
      begin
        if (!all_low)
        begin
          next_s.prog = scc_pkg::SCC_ARMED;
        end
      end
      default:
      begin
        next_s.prog = scc_pkg::SCC_ARMED;
      end
    endcase
    next_s.open_loop = loop_select_input;
    // Input style decode.
    if (s.cfg[`SCC_BIT_STYLE])
    begin
      style_en = !((!phase_a_input && !phase_a_bar_input)
                || (!phase_b_input && !phase_b_bar_input));
      next_s.drive = {phase_b_bar_input, phase_b_input, phase_a_bar_input, phase_a_input};
      next_s.reduced = (phase_a_input && phase_a_bar_input)
                    || (phase_b_input && phase_b_bar_input)
                    || reduction_request_input
                    || (active == 3'd1);
    end
    else
    begin
      style_en = phase_b_input;
      next_s.drive = {!phase_a_bar_input, phase_a_bar_input, !phase_a_input, phase_a_input};
      next_s.reduced = !phase_b_bar_input || reduction_request_input;
    end
    next_s.out_en = style_en && !all_low && !ext_reset_request
                 && !(s.open_loop && ton_off);
    if (!next_s.out_en)
    begin
      next_s.drive = 4'h0;
    end
    // Reference level, reduced only in closed loop.
    if (s.reduced && !s.open_loop)
    begin
      pct = level_pct(s.cfg);
    end
    next_s.ref_mv = 10'((`SCC_NOM_REF_MV * int'(pct)) / 100);
    // Chopping.
    if (osc_pulse)
    begin
      next_s.div_tog = !s.div_tog;
    end
    if (s.open_loop)
    begin
      next_s.chop_on = !ton_off && (osc_cnt < on_limit(s.cfg));
    end
    else if (chop_pulse)
    begin
      next_s.chop_on = 1'b1;
    end
    else if (over_threshold)
    begin
      next_s.chop_on = 1'b0;
    end
    if (ext_reset_request)
    begin
      next_s.cfg = `SCC_CFG_RESET;
      next_s.prog = scc_pkg::SCC_ARMED;
      next_s.chop_on = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign drive_out = s.drive;
  assign chop_on = s.chop_on;
  assign output_enable = s.out_en;
  assign reduced_current = s.reduced;
  assign ref_level_mv = s.ref_mv;
  assign open_loop = s.open_loop;
  assign full_input_style = s.cfg[`SCC_BIT_STYLE];
  assign config_word = s.cfg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_open_full_rate: assert property (@(posedge clk) disable iff (!rstn)
    (s.open_loop && osc_pulse && !ton_off && !ext_reset_request) |=> s.chop_on)
    else $error("Open loop missed an oscillator pulse.");

  chk_half_on_time: assert property (@(posedge clk) disable iff (!rstn)
    (s.open_loop && s.cfg[3:2] == 2'b10 && osc_cnt == THR_50) |=> !s.chop_on)
    else $error("Half on-time did not end at mid period.");

  chk_ton_disable: assert property (@(posedge clk) disable iff (!rstn)
    (s.open_loop && s.cfg[3:2] == 2'b11) |=> !s.out_en)
    else $error("On-time code 11 left the output enabled.");

  chk_divide_skip: assert property (@(posedge clk) disable iff (!rstn)
    (!s.open_loop && s.cfg[4] && osc_pulse && !s.div_tog && !s.chop_on) |=> !s.chop_on)
    else $error("Divided chop started on a skipped pulse.");

  chk_level_forty: assert property (@(posedge clk) disable iff (!rstn)
    (s.reduced && !s.open_loop && s.cfg[1:0] == 2'b00) |=> (s.ref_mv == 10'd200))
    else $error("Reduced level 00 is not 40 percent.");

  chk_full_reduce: assert property (@(posedge clk) disable iff (!rstn)
    (s.cfg[5] && phase_a_input && phase_a_bar_input) |=> s.reduced)
    else $error("Full style missed a reduction request.");

  chk_simple_reduce: assert property (@(posedge clk) disable iff (!rstn)
    (!s.cfg[5] && phase_b_bar_input && !reduction_request_input) |=> !s.reduced)
    else $error("Simplified style reduced without a request.");

  chk_pair_disable: assert property (@(posedge clk) disable iff (!rstn)
    (s.cfg[5] && !phase_b_input && !phase_b_bar_input) |=> !s.out_en)
    else $error("Output stayed enabled with both B inputs low.");

  chk_shift_in: assert property (@(posedge clk) disable iff (!rstn)
    (s.prog == scc_pkg::SCC_LOW_WAIT && s.low_cnt >= LOW_LAST && all_low && !ext_reset_request)
    |=> (s.cfg == {$past(s.cfg[4:0]), $past(ser_bit)}))
    else $error("Configuration bit was not shifted in.");

  chk_no_shift: assert property (@(posedge clk) disable iff (!rstn)
    (!all_low && !ext_reset_request) |=> $stable(s.cfg))
    else $error("Configuration changed outside programming.");

  chk_comp_end: assert property (@(posedge clk) disable iff (!rstn)
    (!s.open_loop && over_threshold && !chop_pulse) |=> !s.chop_on)
    else $error("Comparator did not end the on-period.");

  cov_shift: cover property (@(posedge clk) disable iff (!rstn)
    s.prog == scc_pkg::SCC_LOW_WAIT ##1 s.prog == scc_pkg::SCC_SHIFTED);
  cov_closed_chop: cover property (@(posedge clk) disable iff (!rstn)
    !s.open_loop && s.chop_on ##1 !s.chop_on);
  cov_full_style: cover property (@(posedge clk) disable iff (!rstn)
    s.cfg[5] && s.out_en && s.reduced);

endmodule

// *** test/scc_host.sv ***
// Host model driving the phase and control inputs.
`timescale 1ns/1ps

module scc_host (
  input wire logic clk,
  output logic [3:0] ph,
  output logic red,
  output logic loop
);
  initial
  begin
    ph = 4'h0;
    red = 1'b0;
    loop = 1'b0;
  end

  task automatic drive(input logic [3:0] p, input logic r, input logic l);
    @(negedge clk);
    ph <= p;
    red <= r;
    loop <= l;
  endtask

  // Holds all four phases low for n cycles, then raises two (A and B) so the next bit can follow.
  task automatic shift_bit(input logic r, input logic l, input int n);
    drive(4'h0, r, l);
    repeat (n) @(negedge clk);
    ph <= 4'h5;
    @(negedge clk);
  endtask
endmodule

// *** test/tb_stepper_chop_current_select.sv ***
// Testbench for the stepper chop and current select block.
`timescale 1ns/1ps

module tb_stepper_chop_current_select;
  localparam int P = 40;
  logic clk = 1'b0;
  logic rstn;
  logic over_threshold;
  logic ext_reset_request;
  logic [3:0] ph;
  logic red;
  logic loop;
  logic [3:0] drive_out;
  logic chop_on;
  logic output_enable;
  logic reduced_current;
  logic [9:0] ref_level_mv;
  logic open_loop;
  logic full_input_style;
  logic [5:0] config_word;
  int failures = 0;
  int comparisons = 0;
  int rises;
  int highs;
  int h75;
  // Rows: phases, drive, then style, request, enable, reduced.
  logic [11:0] rows [12] = '{12'hd92, 12'he62, 12'h663, 12'hd97, 12'hb00, 12'h55a,
    12'h55f, 12'h309, 12'hc09, 12'h109, 12'haaa, 12'hffb};
  logic [15:0] lv [4] = '{16'h00c8, 16'h015e, 16'h00fa, 16'h01a9};

  scc_host scc_host_inst (
    .clk,
    .ph,
    .red,
    .loop
  );

  scc_top #(.OSC_PERIOD(P), .PROG_LOW_CYC(4)) scc_top_inst (
    .clk,
    .rstn,
    .phase_a_input(ph[0]),
    .phase_a_bar_input(ph[1]),
    .phase_b_input(ph[2]),
    .phase_b_bar_input(ph[3]),
    .reduction_request_input(red),
    .loop_select_input(loop),
    .over_threshold,
    .ext_reset_request,
    .drive_out,
    .chop_on,
    .output_enable,
    .reduced_current,
    .ref_level_mv,
    .open_loop,
    .full_input_style,
    .config_word
  );

  // ----------------------------------------
  // Clock, checks and watchdog
  // ----------------------------------------
  always #5 clk = ~clk;

  task automatic close_out;
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // Sends the word top bit first; odd bits drive the request input inverted with the loop input set, so the XOR is the bit.
  task automatic prog(input logic [5:0] c);
    for (int i = 5; i >= 0; i--)
      scc_host_inst.shift_bit(c[i] ^ i[0], i[0], 5);
    chk(16'(config_word), 16'(c));
    chk(16'(full_input_style), 16'(c[5]));
  endtask

  // Counts chop starts and on-cycles over four oscillator periods.
  task automatic run(input logic [5:0] c, input logic l);
    logic prev;
    prog(c);
    scc_host_inst.drive(4'h5, 1'b0, l);
    repeat (2 * P) @(negedge clk);
    rises = 0;
    highs = 0;
    prev = chop_on;
    repeat (4 * P)
    begin
      @(negedge clk);
      rises += int'(chop_on & ~prev);
      highs += int'(chop_on);
      prev = chop_on;
    end
  endtask

  initial
  begin
    #200us;
    failures++;
    close_out;
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    logic cur;
    rstn = 1'b0;
    over_threshold = 1'b0;
    ext_reset_request = 1'b0;
    cur = 1'b0;
    repeat (6) @(negedge clk);
    chk(16'({drive_out, chop_on, output_enable, reduced_current, open_loop}), 16'h0000);
    chk(16'({ref_level_mv, config_word}), 16'h0000);
    rstn = 1'b1;
    foreach (rows[i])
    begin
      if (rows[i][3] !== cur)
      begin
        prog({rows[i][3], 5'h00});
        cur = rows[i][3];
      end
      scc_host_inst.drive(rows[i][11:8], rows[i][2], 1'b0);
      repeat (2) @(negedge clk);
      chk(16'(output_enable), 16'(rows[i][1]));
      chk(16'(reduced_current), 16'(rows[i][0]));
      chk(16'(drive_out), 16'(rows[i][7:4]));
    end
    scc_host_inst.shift_bit(1'b1, 1'b0, 3);
    chk(16'(config_word), 16'h0020);
    scc_host_inst.shift_bit(1'b1, 1'b0, 12);
    chk(16'(config_word), 16'h0001);
    for (int c = 0; c < 4; c++)
    begin
      prog(6'h20 + 6'(c));
      scc_host_inst.drive(4'h5, 1'b1, 1'b0);
      repeat (3) @(negedge clk);
      chk(16'(ref_level_mv), lv[c]);
    end
    scc_host_inst.drive(4'h5, 1'b0, 1'b0);
    repeat (3) @(negedge clk);
    chk(16'(ref_level_mv), 16'h01f4);
    over_threshold = 1'b1;
    run(6'h23, 1'b0);
    chk(16'(rises), 16'h0004);
    chk(16'(highs), 16'h0004);
    run(6'h30, 1'b0);
    chk(16'(rises), 16'h0002);
    over_threshold = 1'b0;
    run(6'h30, 1'b1);
    chk(16'(open_loop), 16'h0001);
    chk(16'(rises), 16'h0004);
    h75 = highs;
    run(6'h38, 1'b1);
    chk(16'(h75 - highs), 16'(P));
    run(6'h34, 1'b1);
    chk(16'(highs), 16'(4 * P));
    run(6'h3c, 1'b1);
    chk(16'({highs[7:0], output_enable}), 16'h0000);
    ext_reset_request = 1'b1;
    @(negedge clk);
    chk(16'({config_word, chop_on, output_enable}), 16'h0000);
    ext_reset_request = 1'b0;
    @(negedge clk);
    chk(16'(output_enable), 16'h0001);
    close_out;
  end
endmodule
